// ===== src/eprf_consts.svh
`ifndef EPRF_CONSTS_SVH
`define EPRF_CONSTS_SVH

// ****************************************
// register byte addresses
// ****************************************
`define EPRF_FLAGS_RD_ADDR  12'h0C8
`define EPRF_FLAGS_WR_ADDR  12'h048
`define EPRF_ENABLE_ADDR    12'h0CC
`define EPRF_CAUSE_ADDR     12'h0D0
`define EPRF_SETUP_ADDR     12'h0D4

// ****************************************
// flag bit positions
// ****************************************
`define EPRF_EP0_RX_BIT     0
`define EPRF_EP1_RX_BIT     1
`define EPRF_EP2_RX_BIT     2
`define EPRF_ZERO_BIT       3
`define EPRF_EP0_TX_BIT     4
`define EPRF_EP1_TX_BIT     5
`define EPRF_EP2_TX_BIT     6
`define EPRF_SETUP_RDY_BIT  0

// ****************************************
// reset values
// ****************************************
`define EPRF_FLAGS_RESET    8'h00
`define EPRF_ENABLE_RESET   8'h00

`endif

// ===== src/eprf_pkg.sv
package eprf_pkg;

  typedef logic [7:0] eprf_byte_type;

  typedef enum logic {
    EPRF_APB_IDLE,
    EPRF_APB_ANSWER
  } eprf_apb_state_type;

endpackage : eprf_pkg

// ===== src/eprf_dual_layer.sv
`timescale 1ns/1ps

// two-layer ready flags filled and drained in turn
module eprf_dual_layer (
  input  wire logic clk_i,
  input  wire logic reset_n_i,
  input  wire logic clear_i,
  input  wire logic fill_i,
  input  wire logic drain_i,
  output logic      any_o,
  output logic      both_o,
  output logic      none_o
);

  logic layer_a_q;
  logic layer_b_q;
  logic fill_sel_q;
  logic drain_sel_q;

  wire  fill_ok   = fill_i & ~(layer_a_q & layer_b_q);
  wire  drain_ok  = drain_i & (layer_a_q | layer_b_q);
  wire  fill_a    = fill_ok & ~fill_sel_q;
  wire  fill_b    = fill_ok & fill_sel_q;
  wire  drain_a   = drain_ok & ~drain_sel_q;
  wire  drain_b   = drain_ok & drain_sel_q;
  wire  layer_a_d = ~clear_i & ((layer_a_q & ~drain_a) | fill_a);
  wire  layer_b_d = ~clear_i & ((layer_b_q & ~drain_b) | fill_b);

  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i || clear_i)
    begin
      layer_a_q   <= 1'b0;
      layer_b_q   <= 1'b0;
      fill_sel_q  <= 1'b0;
      drain_sel_q <= 1'b0;
      any_o       <= 1'b0;
      both_o      <= 1'b0;
      none_o      <= 1'b1;
    end
    else
    begin
      layer_a_q   <= layer_a_d;
      layer_b_q   <= layer_b_d;
      fill_sel_q  <= fill_sel_q ^ fill_ok;
      drain_sel_q <= drain_sel_q ^ drain_ok;
      any_o       <= layer_a_d | layer_b_d;
      both_o      <= layer_a_d & layer_b_d;
      none_o      <= ~(layer_a_d | layer_b_d);
    end
  end

endmodule : eprf_dual_layer

// ===== src/eprf_apb_port.sv
`timescale 1ns/1ps

// apb slave with one wait state and registered answer
module eprf_apb_port (
  input  wire logic        clk_i,
  input  wire logic        reset_n_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic        mapped_i,
  input  wire logic [31:0] rd_data_i,
  output logic             wr_en_o,
  output logic             pready_o,
  output logic [31:0]      prdata_o,
  output logic             pslverr_o
);

  eprf_pkg::eprf_apb_state_type state_q;

  wire access = psel_i & penable_i;
  wire start  = access & (state_q == eprf_pkg::EPRF_APB_IDLE);

  assign wr_en_o = access & pready_o & pwrite_i;

  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i)
    begin
      state_q   <= eprf_pkg::EPRF_APB_IDLE;
      pready_o  <= 1'b0;
      prdata_o  <= 32'h0000_0000;
      pslverr_o <= 1'b0;
    end
    else
    begin
      case (state_q)
        eprf_pkg::EPRF_APB_IDLE:
        begin
          state_q   <= start ? eprf_pkg::EPRF_APB_ANSWER : eprf_pkg::EPRF_APB_IDLE;
          pready_o  <= start;
          prdata_o  <= (start && !pwrite_i) ? rd_data_i : 32'h0000_0000;
          pslverr_o <= start & ~mapped_i;
        end
        default:
        begin
          state_q   <= eprf_pkg::EPRF_APB_IDLE;
          pready_o  <= 1'b0;
          pslverr_o <= 1'b0;
        end
      endcase
    end
  end

endmodule : eprf_apb_port

// ===== src/eprf_top.sv
`timescale 1ns/1ps
`include "eprf_consts.svh"

// How it works
// - flags read at C8h, written at 48h
// - cause bit is flag AND enable
// - receive flag set on packet, host clears
// - transmit flag cleared by device, host sets
// - bit three reads zero, writes ignored
// - writing one clears a receive flag
// - writing one sets a transmit flag
// - endpoint zero flag set on stored packet
// - endpoint zero flag set on setup packet
// - endpoint zero locked and NAKs while set
// - cleared by write, or by setup-ready clear during a control write
// - endpoint one has two switching layers
// - endpoint one receive flag set by either layer, transmit flag only by both
// - endpoint one locked only when both full
// - endpoint one flag drops when both released
// - endpoint one accepts once a layer frees
// - endpoint two flag set, locks endpoint
// - writing one releases endpoint two
// - host ack clears transmit flag; IN NAKed, ep1 only once no layer is left
module eprf_top #(
  parameter int ADDR_W = 12
) (
  input  wire logic              clk_i,
  input  wire logic              reset_n_i,
  input  wire logic              psel_i,
  input  wire logic              penable_i,
  input  wire logic              pwrite_i,
  input  wire logic [ADDR_W-1:0] paddr_i,
  input  wire logic [31:0]       pwdata_i,
  output logic                   pready_o,
  output logic [31:0]            prdata_o,
  output logic                   pslverr_o,
  input  wire logic              usb_reset_i,
  input  wire logic              ep0_rx_done_i,
  input  wire logic              setup_rx_i,
  input  wire logic              control_write_i,
  input  wire logic              ep1_rx_done_i,
  input  wire logic              ep2_rx_done_i,
  input  wire logic              ep0_tx_ack_i,
  input  wire logic              ep1_tx_ack_i,
  input  wire logic              ep2_tx_ack_i,
  output logic                   ep0_rx_nak_o,
  output logic                   ep1_rx_nak_o,
  output logic                   ep2_rx_nak_o,
  output logic                   ep0_in_nak_o,
  output logic                   ep1_in_nak_o,
  output logic                   ep2_in_nak_o,
  output logic [7:0]             interrupt_cause_o
);

  // ****************************************
  // parameter check
  // ****************************************
  if (ADDR_W < 8 || ADDR_W > 12)
  begin : g_addr_check
    $error("eprf_top: ADDR_W must lie between 8 and 12");
  end

  // ****************************************
  // address decode
  // ****************************************
  logic                   wr_en;
  logic                   setup_ready_q;
  logic [3:0]             single_q;
  logic                   ep1_rx_any;
  logic                   ep1_rx_both;
  logic                   ep1_tx_any;
  logic                   ep1_tx_both;
  logic                   ep1_tx_none;
  eprf_pkg::eprf_byte_type mask_q;

  wire [11:0] addr     = 12'(paddr_i);
  wire [7:0]  wdata    = pwdata_i[7:0];
  wire        hit_rd   = (addr == `EPRF_FLAGS_RD_ADDR);
  wire        hit_wr   = (addr == `EPRF_FLAGS_WR_ADDR);
  wire        hit_en   = (addr == `EPRF_ENABLE_ADDR);
  wire        hit_ca   = (addr == `EPRF_CAUSE_ADDR);
  wire        hit_su   = (addr == `EPRF_SETUP_ADDR);
  wire        mapped   = hit_rd | hit_wr | hit_en | hit_ca | hit_su;
  wire        flag_wr  = wr_en & hit_wr;
  wire        mask_wr  = wr_en & hit_en;
  wire        setup_wr = wr_en & hit_su & wdata[`EPRF_SETUP_RDY_BIT];

  // ****************************************
  // flag byte and read data
  // ****************************************
  wire [7:0] flags_now = {1'b0, single_q[3], ep1_tx_both, single_q[2],
                          1'b0, single_q[1], ep1_rx_any, single_q[0]};
  wire [7:0] cause_now = flags_now & mask_q;

  logic [7:0] rd_byte;
  always_comb
  begin
    if (hit_rd)
      rd_byte = flags_now;
    else if (hit_en)
      rd_byte = mask_q;
    else if (hit_ca)
      rd_byte = cause_now;
    else if (hit_su)
      rd_byte = {7'h00, setup_ready_q};
    else
      rd_byte = 8'h00;
  end

  eprf_apb_port u_apb (
    .clk_i     (clk_i),
    .reset_n_i (reset_n_i),
    .psel_i    (psel_i),
    .penable_i (penable_i),
    .pwrite_i  (pwrite_i),
    .mapped_i  (mapped),
    .rd_data_i ({24'h00_0000, rd_byte}),
    .wr_en_o   (wr_en),
    .pready_o  (pready_o),
    .prdata_o  (prdata_o),
    .pslverr_o (pslverr_o)
  );

  // ****************************************
  // single-layer flags: ep0 rx, ep2 rx, ep0 tx, ep2 tx
  // ****************************************
  wire ep0_clr = flag_wr & wdata[`EPRF_EP0_RX_BIT];
  wire su_clr  = setup_wr & setup_ready_q & control_write_i;
  wire [3:0] set_v = {flag_wr & wdata[`EPRF_EP2_TX_BIT],
                      flag_wr & wdata[`EPRF_EP0_TX_BIT],
                      ep2_rx_done_i,
                      ep0_rx_done_i | setup_rx_i};
  wire [3:0] clr_v = {ep2_tx_ack_i,
                      ep0_tx_ack_i | setup_rx_i,
                      flag_wr & wdata[`EPRF_EP2_RX_BIT],
                      ep0_clr | su_clr};
  wire [3:0] single_d;

  genvar gi;
  for (gi = 0; gi < 4; gi++)
  begin : g_single
    // set wins over clear; bus reset wins over both
    assign single_d[gi] = ~usb_reset_i & ((single_q[gi] & ~clr_v[gi]) | set_v[gi]);
    always_ff @(posedge clk_i)
    begin
      if (!reset_n_i)
        single_q[gi] <= 1'b0;
      else
        single_q[gi] <= single_d[gi];
    end
  end

  // ****************************************
  // endpoint one layers
  // ****************************************
  eprf_dual_layer u_ep1_rx (
    .clk_i     (clk_i),
    .reset_n_i (reset_n_i),
    .clear_i   (usb_reset_i),
    .fill_i    (ep1_rx_done_i),
    .drain_i   (flag_wr & wdata[`EPRF_EP1_RX_BIT]),
    .any_o     (ep1_rx_any),
    .both_o    (ep1_rx_both),
    .none_o    ()
  );

  eprf_dual_layer u_ep1_tx (
    .clk_i     (clk_i),
    .reset_n_i (reset_n_i),
    .clear_i   (usb_reset_i),
    .fill_i    (flag_wr & wdata[`EPRF_EP1_TX_BIT]),
    .drain_i   (ep1_tx_ack_i),
    .any_o     (ep1_tx_any),
    .both_o    (ep1_tx_both),
    .none_o    (ep1_tx_none)
  );

  // ****************************************
  // enable mask, setup ready, cause and lock outputs
  // ****************************************
  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i)
    begin
      mask_q            <= `EPRF_ENABLE_RESET;
      setup_ready_q     <= 1'b0;
      interrupt_cause_o <= `EPRF_FLAGS_RESET;
      ep0_rx_nak_o      <= 1'b0;
      ep2_rx_nak_o      <= 1'b0;
      ep0_in_nak_o      <= 1'b1;
      ep2_in_nak_o      <= 1'b1;
    end
    else
    begin
      mask_q            <= mask_wr ? wdata : mask_q;
      setup_ready_q     <= ~usb_reset_i & (setup_rx_i | (setup_ready_q & ~setup_wr));
      interrupt_cause_o <= cause_now;
      ep0_rx_nak_o      <= single_d[0];
      ep2_rx_nak_o      <= single_d[1];
      ep0_in_nak_o      <= ~single_d[2];
      ep2_in_nak_o      <= ~single_d[3];
    end
  end

  assign ep1_rx_nak_o = ep1_rx_both;
  assign ep1_in_nak_o = ep1_tx_none;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!reset_n_i);

  flags_read_a : assert property (
    psel_i && penable_i && !pready_o && !pwrite_i && hit_rd
    |=> pready_o && prdata_o == {24'h00_0000, $past(flags_now)})
    else $error("flag read returned wrong data");

  cause_and_a : assert property (
    interrupt_cause_o == $past(flags_now & mask_q))
    else $error("cause is not flag and enable");

  bit_three_a : assert property (
    psel_i && penable_i && !pready_o && !pwrite_i && hit_rd
    |=> prdata_o[`EPRF_ZERO_BIT] == 1'b0)
    else $error("bit three read as one");

  ep0_rx_set_a : assert property (
    (ep0_rx_done_i || setup_rx_i) && !usb_reset_i
    |=> single_q[0] && ep0_rx_nak_o)
    else $error("ep0 receive flag not set");

  rx_clear_a : assert property (
    ep0_clr && !setup_rx_i && !ep0_rx_done_i && !usb_reset_i |=> !single_q[0])
    else $error("ep0 receive flag not cleared");

  setup_clear_a : assert property (
    su_clr && !setup_rx_i && !ep0_rx_done_i |=> !single_q[0] && !setup_ready_q)
    else $error("setup ready clear missed ep0 flag");

  tx_set_a : assert property (
    flag_wr && wdata[`EPRF_EP2_TX_BIT] && !usb_reset_i
    |=> single_q[3] && !ep2_in_nak_o)
    else $error("ep2 transmit flag not set");

  tx_ack_a : assert property (
    ep0_tx_ack_i && !(flag_wr && wdata[`EPRF_EP0_TX_BIT]) |=> ep0_in_nak_o && !single_q[2])
    else $error("ep0 in not nak after ack");

  ep1_lock_a : assert property (
    ep1_rx_nak_o && ep1_rx_done_i && !usb_reset_i
    && !(flag_wr && wdata[`EPRF_EP1_RX_BIT])
    |=> ep1_rx_nak_o && ep1_rx_any)
    else $error("ep1 lock lost on refused packet");

  ep1_free_a : assert property (
    ep1_rx_both && flag_wr && wdata[`EPRF_EP1_RX_BIT] && !ep1_rx_done_i && !usb_reset_i
    |=> !ep1_rx_nak_o && ep1_rx_any)
    else $error("ep1 not freed after one release");

  ep2_release_a : assert property (
    single_q[1] && flag_wr && wdata[`EPRF_EP2_RX_BIT] && !ep2_rx_done_i
    |=> !single_q[1] && !ep2_rx_nak_o)
    else $error("ep2 not released");

  bus_reset_a : assert property (
    usb_reset_i |=> flags_now == `EPRF_FLAGS_RESET ##1 interrupt_cause_o == 8'h00)
    else $error("bus reset left a flag set");

  ep1_fill_a : assert property (
    !ep1_rx_any && ep1_rx_done_i && !usb_reset_i
    |=> ep1_rx_any && !ep1_rx_nak_o)
    else $error("ep1 first packet not flagged");

  ep1_second_a : assert property (
    ep1_rx_any && !ep1_rx_nak_o && ep1_rx_done_i && !usb_reset_i
    && !(flag_wr && wdata[`EPRF_EP1_RX_BIT])
    |=> ep1_rx_nak_o)
    else $error("ep1 not locked with both layers full");

  ep1_drop_a : assert property (
    ep1_rx_any && !ep1_rx_nak_o && flag_wr && wdata[`EPRF_EP1_RX_BIT]
    && !ep1_rx_done_i && !usb_reset_i
    |=> !ep1_rx_any)
    else $error("ep1 flag kept after last release");

  ep2_set_a : assert property (
    ep2_rx_done_i && !usb_reset_i |=> single_q[1] && ep2_rx_nak_o)
    else $error("ep2 receive flag not set");

  tx0_set_a : assert property (
    flag_wr && wdata[`EPRF_EP0_TX_BIT] && !usb_reset_i |=> single_q[2] && !ep0_in_nak_o)
    else $error("ep0 transmit flag not set");

  ep1_tx_load_a : assert property (
    ep1_tx_none && flag_wr && wdata[`EPRF_EP1_TX_BIT] && !usb_reset_i
    |=> !ep1_in_nak_o && !ep1_tx_both)
    else $error("ep1 transmit layer not loaded");

  ep1_tx_ack_a : assert property (
    ep1_tx_both && ep1_tx_ack_i && !(flag_wr && wdata[`EPRF_EP1_TX_BIT]) && !usb_reset_i
    |=> !ep1_tx_both && !ep1_in_nak_o)
    else $error("ep1 transmit ack not handled");

  ep2_tx_ack_a : assert property (
    ep2_tx_ack_i && !(flag_wr && wdata[`EPRF_EP2_TX_BIT]) |=> ep2_in_nak_o && !single_q[3])
    else $error("ep2 in not nak after ack");

  setup_set_a : assert property (
    setup_rx_i && !usb_reset_i |=> single_q[0] && setup_ready_q)
    else $error("setup packet not flagged");

  setup_keep_a : assert property (
    setup_wr && !control_write_i && single_q[0] && !ep0_clr && !usb_reset_i
    |=> single_q[0])
    else $error("ep0 flag cleared outside control write");

  pready_once_a : assert property (
    pready_o |=> !pready_o)
    else $error("ready held longer than one cycle");

  unmapped_a : assert property (
    psel_i && penable_i && !pready_o && !mapped
    |=> pready_o && pslverr_o && prdata_o == 32'h0000_0000)
    else $error("unmapped access not refused");

  cause_read_a : assert property (
    psel_i && penable_i && !pready_o && !pwrite_i && hit_ca
    |=> prdata_o[7:0] == $past(flags_now & mask_q))
    else $error("cause read is not flag and enable");

  bus_reset_nak_a : assert property (
    usb_reset_i |=> !ep0_rx_nak_o && !ep1_rx_nak_o && !ep2_rx_nak_o
    && ep0_in_nak_o && ep1_in_nak_o && ep2_in_nak_o)
    else $error("bus reset left an endpoint open");

endmodule : eprf_top

// ===== verif/eprf_usb_host.sv
`timescale 1ns/1ps

// ****************************************
// usb host side event source
// ****************************************
// bit order of ev_o: 0 ep0 rx, 1 ep1 rx, 2 ep2 rx, 3 setup,
// 4 ep0 ack, 5 ep1 ack, 6 ep2 ack, 7 bus reset
module eprf_usb_host (
  input  wire logic       clk_i,
  output logic      [7:0] ev_o
);
  initial ev_o = 8'h00;

  // one clock wide event, launched just after an edge
  task automatic pulse(input int idx);
    @(posedge clk_i);
    ev_o <= 8'h01 << idx;
    @(posedge clk_i);
    ev_o <= 8'h00;
  endtask : pulse
endmodule : eprf_usb_host

// ===== verif/eprf_tb.sv
`timescale 1ns/1ps

`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin failures++; \
  $display("MISMATCH %s expected %h seen %h", n, e, g); end end

module testbench;
  logic        clk_i;
  logic        reset_n_i;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic        pready_o;
  logic [31:0] prdata_o;
  logic        pslverr_o;
  logic        ctl_wr;
  logic [7:0]  ev;
  logic [2:0]  rx_nak;
  logic [2:0]  in_nak;
  logic [7:0]  cause;
  logic [31:0] rdat;
  logic        rerr;
  int          failures;
  int          num_checks;

  // ****************************************
  // clock, partner and design
  // ****************************************
  initial
  begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end

  eprf_usb_host host (.clk_i(clk_i), .ev_o(ev));

  eprf_top #(.ADDR_W(12)) dut (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .pready_o(pready_o),
    .prdata_o(prdata_o), .pslverr_o(pslverr_o), .usb_reset_i(ev[7]),
    .ep0_rx_done_i(ev[0]), .setup_rx_i(ev[3]), .control_write_i(ctl_wr),
    .ep1_rx_done_i(ev[1]), .ep2_rx_done_i(ev[2]), .ep0_tx_ack_i(ev[4]),
    .ep1_tx_ack_i(ev[5]), .ep2_tx_ack_i(ev[6]), .ep0_rx_nak_o(rx_nak[0]),
    .ep1_rx_nak_o(rx_nak[1]), .ep2_rx_nak_o(rx_nak[2]), .ep0_in_nak_o(in_nak[0]),
    .ep1_in_nak_o(in_nak[1]), .ep2_in_nak_o(in_nak[2]), .interrupt_cause_o(cause)
  );

  // ****************************************
  // apb master
  // ****************************************
  task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d);
    @(posedge clk_i);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge clk_i);
    penable <= 1'b1;
    do
    begin
      @(posedge clk_i);
    end
    while (pready_o !== 1'b1);
    rdat = prdata_o;
    rerr = pslverr_o;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rd_chk(input string nm, input logic [11:0] a, input logic [7:0] e);
    apb(1'b0, a, 8'h00);
    `CHK(nm, {24'h000000, e}, rdat)
  endtask : rd_chk

  task automatic settle;
    @(posedge clk_i);
    #1;
  endtask : settle

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset;
    rd_chk("flags after reset", 12'h0C8, 8'h00);
    rd_chk("mask after reset", 12'h0CC, 8'h00);
    `CHK("in nak after reset", 3'b111, in_nak)
    `CHK("rx nak after reset", 3'b000, rx_nak)
    $display("test reset done");
  endtask : t_reset

  task automatic t_ep2;
    host.pulse(2);
    settle();
    `CHK("ep2 lock", 1'b1, rx_nak[2])
    rd_chk("ep2 flag", 12'h0C8, 8'h04);
    apb(1'b1, 12'h048, 8'h00);
    rd_chk("zero write keeps", 12'h0C8, 8'h04);
    apb(1'b1, 12'h048, 8'h04);
    rd_chk("ep2 released", 12'h0C8, 8'h00);
    `CHK("ep2 unlock", 1'b0, rx_nak[2])
    $display("test ep2 done");
  endtask : t_ep2

  task automatic t_ep0;
    host.pulse(0);
    settle();
    `CHK("ep0 lock", 1'b1, rx_nak[0])
    rd_chk("ep0 flag", 12'h0C8, 8'h01);
    apb(1'b1, 12'h048, 8'h01);
    rd_chk("ep0 cleared", 12'h0C8, 8'h00);
    ctl_wr <= 1'b1;
    host.pulse(3);
    rd_chk("setup sets ep0", 12'h0C8, 8'h01);
    apb(1'b1, 12'h0D4, 8'h01);
    rd_chk("setup clear", 12'h0C8, 8'h00);
    ctl_wr <= 1'b0;
    host.pulse(3);
    rd_chk("setup ready set", 12'h0D4, 8'h01);
    apb(1'b1, 12'h0D4, 8'h01);
    rd_chk("setup ready cleared", 12'h0D4, 8'h00);
    rd_chk("no control write keeps", 12'h0C8, 8'h01);
    apb(1'b1, 12'h048, 8'h01);
    rd_chk("ep0 released again", 12'h0C8, 8'h00);
    $display("test ep0 done");
  endtask : t_ep0

  task automatic t_ep1;
    host.pulse(1);
    settle();
    `CHK("one layer no lock", 1'b0, rx_nak[1])
    rd_chk("ep1 flag", 12'h0C8, 8'h02);
    host.pulse(1);
    settle();
    `CHK("both layers lock", 1'b1, rx_nak[1])
    host.pulse(1);
    apb(1'b1, 12'h048, 8'h02);
    settle();
    `CHK("one freed accepts", 1'b0, rx_nak[1])
    rd_chk("flag while one held", 12'h0C8, 8'h02);
    apb(1'b1, 12'h048, 8'h02);
    rd_chk("both released", 12'h0C8, 8'h00);
    $display("test ep1 done");
  endtask : t_ep1

  task automatic t_tx;
    apb(1'b1, 12'h048, 8'h58);
    rd_chk("tx set, d3 zero", 12'h0C8, 8'h50);
    `CHK("ep0 in open", 1'b0, in_nak[0])
    `CHK("ep2 in open", 1'b0, in_nak[2])
    apb(1'b1, 12'h048, 8'h20);
    rd_chk("ep1 one layer", 12'h0C8, 8'h50);
    `CHK("ep1 in open", 1'b0, in_nak[1])
    apb(1'b1, 12'h048, 8'h20);
    rd_chk("ep1 both layers", 12'h0C8, 8'h70);
    host.pulse(4);
    host.pulse(5);
    settle();
    `CHK("ep0 in nak", 1'b1, in_nak[0])
    rd_chk("acks clear tx", 12'h0C8, 8'h40);
    $display("test tx done");
  endtask : t_tx

  task automatic t_cause;
    apb(1'b1, 12'h0CC, 8'h05);
    host.pulse(2);
    rd_chk("cause read", 12'h0D0, 8'h04);
    `CHK("cause port", 8'h04, cause)
    apb(1'b1, 12'h0C8, 8'hFF);
    rd_chk("read addr not writable", 12'h0C8, 8'h44);
    rd_chk("write addr reads zero", 12'h048, 8'h00);
    apb(1'b0, 12'h010, 8'h00);
    `CHK("unmapped error", 1'b1, rerr)
    host.pulse(6);
    settle();
    `CHK("ep2 in nak", 1'b1, in_nak[2])
    rd_chk("ep2 ack clears tx", 12'h0C8, 8'h04);
    $display("test cause done");
  endtask : t_cause

  task automatic t_bus_reset;
    host.pulse(7);
    rd_chk("bus reset clears", 12'h0C8, 8'h00);
    `CHK("bus reset naks", 6'b111000, {in_nak, rx_nak})
    apb(1'b1, 12'h048, 8'h50);
    reset_n_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    reset_n_i <= 1'b1;
    rd_chk("hw reset clears", 12'h0C8, 8'h00);
    rd_chk("hw reset mask", 12'h0CC, 8'h00);
    `CHK("hw reset in nak", 3'b111, in_nak)
    $display("test bus reset done");
  endtask : t_bus_reset

  task automatic test_done;
    $display("checks %0d mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : test_done

  // ****************************************
  // main sequence and watchdog
  // ****************************************
  initial
  begin
    failures = 0;
    num_checks = 0;
    reset_n_i = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h00000000;
    ctl_wr = 1'b0;
    repeat (2) @(posedge clk_i);
    reset_n_i <= 1'b1;
    t_reset();
    t_ep2();
    t_ep0();
    t_ep1();
    t_tx();
    t_cause();
    t_bus_reset();
    test_done();
  end

  initial
  begin
    #200000;
    failures++;
    test_done();
  end
endmodule : testbench
